// ==== logic/drive_state_regs.svh ====
// constants of the drive operating-state machine
`ifndef DRIVE_STATE_REGS_SVH
`define DRIVE_STATE_REGS_SVH

// ==========================================
// reported state codes
`define OPST_START        4'h1
`define OPST_NOT_READY    4'h2
`define OPST_SW_ON_DIS    4'h3
`define OPST_READY        4'h4
`define OPST_SWITCHED_ON  4'h5
`define OPST_OP_ENABLED   4'h6
`define OPST_QUICK_STOP   4'h7
`define OPST_FAULT_REACT  4'h8
`define OPST_FAULT        4'h9

// ==========================================
// error classes
`define ERR_CLASS_0       3'h0
`define ERR_CLASS_1       3'h1
`define ERR_CLASS_2       3'h2
`define ERR_CLASS_3       3'h3
`define ERR_CLASS_4       3'h4

// ==========================================
// pin synchroniser
`define SYNC_PIN_COUNT    4
`define SYNC_TORQUE_A     0
`define SYNC_TORQUE_B     1
`define SYNC_LOC_EN       2
`define SYNC_LOC_FR       3

`endif

// ==== logic/drive_state_pkg.sv ====
// types of the drive operating-state machine
package drive_state_pkg;

    // ==========================================
    // operating states, one-hot
    typedef enum logic [8:0] {
        ST_START       = 9'h001,
        ST_NOT_READY   = 9'h002,
        ST_SW_ON_DIS   = 9'h004,
        ST_READY       = 9'h008,
        ST_SWITCHED_ON = 9'h010,
        ST_OP_ENABLED  = 9'h020,
        ST_QUICK_STOP  = 9'h040,
        ST_FAULT_REACT = 9'h080,
        ST_FAULT       = 9'h100
    } op_state_t;

    typedef logic [2:0] err_class_t;

endpackage

// ==== logic/drive_state_machine.sv ====
// nine-state operating-state machine of an integrated motor drive
`timescale 1ns/1ps
`include "drive_state_regs.svh"

module drive_state_machine (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // initialisation progress
    input wire logic elec_init_done,
    input wire logic param_init_done,
    // monitoring
    input wire logic undervoltage,
    input wire logic encoder_test_ok,
    input wire logic speed_over_limit,
    input wire logic torque_off_input_a,
    input wire logic torque_off_input_b,
    input wire logic motor_standstill,
    input wire logic brake_fitted,
    input wire logic brake_applied,
    input wire logic fault_cause_active,
    // error reports
    input wire logic err_valid,
    input wire drive_state_pkg::err_class_t err_class,
    // fieldbus command bits
    input wire logic bus_disable,
    input wire logic bus_enable,
    input wire logic bus_quick_stop,
    input wire logic bus_fault_reset,
    // local signal inputs and their function assignment
    input wire logic local_enable_pin,
    input wire logic local_fault_reset_pin,
    input wire logic local_enable_assigned,
    input wire logic local_fault_reset_assigned,
    // drive commands
    output logic power_stage_en,
    output logic brake_release,
    output logic quick_stop_cmd,
    // status
    output logic [3:0] op_state_code,
    output logic no_fault_out,
    output logic active_out,
    output logic error_flag,
    output logic warn_flag,
    output logic safe_torque_off_trip
);
    import drive_state_pkg::*;

    // ==========================================
    // pin synchronisers, counted once stages two and three agree
    logic [`SYNC_PIN_COUNT-1:0] pin_raw;
    logic [`SYNC_PIN_COUNT-1:0] pin_s1_ff;
    logic [`SYNC_PIN_COUNT-1:0] pin_s2_ff;
    logic [`SYNC_PIN_COUNT-1:0] pin_s3_ff;
    logic [`SYNC_PIN_COUNT-1:0] pin_lvl_ff;
    logic [`SYNC_PIN_COUNT-1:0] pin_rise;
    logic [`SYNC_PIN_COUNT-1:0] pin_fall;

    assign pin_raw = {local_fault_reset_pin, local_enable_pin, torque_off_input_b, torque_off_input_a};

    genvar gi;
    generate
        for (gi = 0; gi < `SYNC_PIN_COUNT; gi = gi + 1) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_s1_ff[gi] <= 1'b0;
                    pin_s2_ff[gi] <= 1'b0;
                    pin_s3_ff[gi] <= 1'b0;
                    pin_lvl_ff[gi] <= 1'b0;
                end else begin
                    pin_s1_ff[gi] <= pin_raw[gi];
                    pin_s2_ff[gi] <= pin_s1_ff[gi];
                    pin_s3_ff[gi] <= pin_s2_ff[gi];
                    if (pin_s2_ff[gi] == pin_s3_ff[gi]) begin
                        pin_lvl_ff[gi] <= pin_s3_ff[gi];
                    end
                end
            end
            assign pin_rise[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) & pin_s3_ff[gi] & ~pin_lvl_ff[gi];
            assign pin_fall[gi] = (pin_s2_ff[gi] == pin_s3_ff[gi]) & ~pin_s3_ff[gi] & pin_lvl_ff[gi];
        end
    endgenerate

    // ==========================================
    // command edges and priorities
    logic [3:0] bus_prev_ff;
    logic [3:0] bus_rise;
    logic en_req, dis_req, qs_req, fr_req;
    logic en_eff, fr_eff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_prev_ff <= 4'h0;
        end else begin
            bus_prev_ff <= {bus_fault_reset, bus_quick_stop, bus_enable, bus_disable};
        end
    end

    // a held bit acts once; it must drop before it can act again
    assign bus_rise = {bus_fault_reset, bus_quick_stop, bus_enable, bus_disable} & ~bus_prev_ff;
    assign en_req = bus_rise[1] | (local_enable_assigned & pin_rise[`SYNC_LOC_EN]);
    assign dis_req = bus_rise[0] | (local_enable_assigned & pin_fall[`SYNC_LOC_EN]);
    assign qs_req = bus_rise[2];
    assign fr_req = bus_rise[3] | (local_fault_reset_assigned & pin_rise[`SYNC_LOC_FR]);
    assign en_eff = en_req & ~dis_req;
    assign fr_eff = fr_req & ~qs_req;

    // ==========================================
    // monitoring terms
    logic torque_ok, ready_ok, heavy_err, class1_err;
    logic torque_trip;

    assign torque_ok = pin_lvl_ff[`SYNC_TORQUE_A] & pin_lvl_ff[`SYNC_TORQUE_B];
    assign ready_ok = ~undervoltage & encoder_test_ok & ~speed_over_limit & torque_ok;
    assign heavy_err = err_valid & (err_class >= `ERR_CLASS_2) & (err_class <= `ERR_CLASS_4);
    assign class1_err = err_valid & (err_class == `ERR_CLASS_1);

    // ==========================================
    // state machine
    op_state_t state_ff, nxt_state;
    err_class_t sev_ff, nxt_sev;
    logic qs_by_err_ff, nxt_qs_by_err;
    logic brake_phase_ff, nxt_brake_phase;
    logic power_ff, nxt_power;
    logic brake_rel_ff, nxt_brake_rel;
    logic qs_cmd_ff, nxt_qs_cmd;
    logic class4_ff;

    assign torque_trip = ~torque_ok & power_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_sev = sev_ff;
        nxt_qs_by_err = qs_by_err_ff;
        nxt_brake_phase = brake_phase_ff;
        nxt_power = power_ff;
        nxt_brake_rel = brake_rel_ff;
        nxt_qs_cmd = 1'b0;
        if (heavy_err || (torque_trip && !state_ff[8])) begin
            nxt_state = ST_FAULT_REACT;
            nxt_sev = heavy_err ? err_class : `ERR_CLASS_3;
            nxt_brake_phase = 1'b0;
            if (!heavy_err || err_class != `ERR_CLASS_2) begin
                nxt_power = 1'b0;
                nxt_brake_rel = 1'b0;
            end else begin
                nxt_qs_cmd = power_ff;
            end
        end else begin
            unique case (state_ff)
                ST_START: begin
                    if (elec_init_done) nxt_state = ST_NOT_READY;
                end
                ST_NOT_READY: begin
                    if (param_init_done) nxt_state = ST_SW_ON_DIS;
                end
                ST_SW_ON_DIS: begin
                    if (ready_ok) nxt_state = ST_READY;
                end
                ST_READY: begin
                    if (undervoltage || !torque_ok || speed_over_limit) begin
                        nxt_state = ST_SW_ON_DIS;
                    end else if (en_eff) begin
                        nxt_state = ST_SWITCHED_ON;
                    end
                end
                ST_SWITCHED_ON: begin
                    if (dis_req) begin
                        nxt_state = ST_SW_ON_DIS;
                    end else begin
                        nxt_state = ST_OP_ENABLED;
                        nxt_power = 1'b1;
                        nxt_brake_rel = brake_fitted;
                    end
                end
                ST_OP_ENABLED: begin
                    if (dis_req) begin
                        nxt_state = ST_SW_ON_DIS;
                        nxt_power = 1'b0;
                        nxt_brake_rel = 1'b0;
                    end else if (class1_err || qs_req) begin
                        nxt_state = ST_QUICK_STOP;
                        nxt_qs_by_err = class1_err;
                        nxt_qs_cmd = 1'b1;
                    end
                end
                ST_QUICK_STOP: begin
                    if (dis_req) begin
                        nxt_state = ST_SW_ON_DIS;
                        nxt_power = 1'b0;
                        nxt_brake_rel = 1'b0;
                    end else if (fr_eff && qs_by_err_ff) begin
                        nxt_state = ST_OP_ENABLED;
                        nxt_qs_by_err = 1'b0;
                    end else begin
                        nxt_qs_cmd = 1'b1;
                    end
                end
                ST_FAULT_REACT: begin
                    if (sev_ff != `ERR_CLASS_2 || !power_ff) begin
                        nxt_state = ST_FAULT;
                        nxt_power = 1'b0;
                        nxt_brake_rel = 1'b0;
                    end else if (!brake_phase_ff) begin
                        nxt_qs_cmd = ~motor_standstill;
                        nxt_brake_phase = motor_standstill;
                        if (motor_standstill) nxt_brake_rel = 1'b0;
                    end else if (brake_applied || !brake_fitted) begin
                        nxt_state = ST_FAULT;
                        nxt_power = 1'b0;
                    end
                end
                ST_FAULT: begin
                    if (fr_eff && sev_ff != `ERR_CLASS_4 && !class4_ff && !fault_cause_active) begin
                        nxt_state = ST_SW_ON_DIS;
                    end
                end
            endcase
        end
    end

    // other requests fall through the case unchanged
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_START;
            sev_ff <= `ERR_CLASS_0;
            qs_by_err_ff <= 1'b0;
            brake_phase_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            sev_ff <= nxt_sev;
            qs_by_err_ff <= nxt_qs_by_err;
            brake_phase_ff <= nxt_brake_phase;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_ff <= 1'b0;
            brake_rel_ff <= 1'b0;
            qs_cmd_ff <= 1'b0;
        end else begin
            power_ff <= nxt_power;
            brake_rel_ff <= nxt_brake_rel;
            qs_cmd_ff <= nxt_qs_cmd;
        end
    end

    // ==========================================
    // error indication; a new report wins over a same-cycle reset
    logic err_ind_ff, warn_ind_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_ind_ff <= 1'b0;
            warn_ind_ff <= 1'b0;
            class4_ff <= 1'b0;
        end else begin
            if (err_valid && err_class >= `ERR_CLASS_1 && err_class <= `ERR_CLASS_3) begin
                err_ind_ff <= 1'b1;
            end else if (fr_eff && !fault_cause_active) begin
                err_ind_ff <= 1'b0;
            end
            if (err_valid && err_class == `ERR_CLASS_0) begin
                warn_ind_ff <= 1'b1;
            end else if (fr_eff) begin
                warn_ind_ff <= 1'b0;
            end
            // only power-on reset clears a class 4 error
            if (err_valid && err_class == `ERR_CLASS_4) begin
                class4_ff <= 1'b1;
            end
        end
    end

    // ==========================================
    // status outputs
    logic [3:0] code_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code_ff <= `OPST_START;
        end else begin
            unique case (nxt_state)
                ST_START:       code_ff <= `OPST_START;
                ST_NOT_READY:   code_ff <= `OPST_NOT_READY;
                ST_SW_ON_DIS:   code_ff <= `OPST_SW_ON_DIS;
                ST_READY:       code_ff <= `OPST_READY;
                ST_SWITCHED_ON: code_ff <= `OPST_SWITCHED_ON;
                ST_OP_ENABLED:  code_ff <= `OPST_OP_ENABLED;
                ST_QUICK_STOP:  code_ff <= `OPST_QUICK_STOP;
                ST_FAULT_REACT: code_ff <= `OPST_FAULT_REACT;
                ST_FAULT:       code_ff <= `OPST_FAULT;
            endcase
        end
    end

    assign op_state_code = code_ff;
    assign power_stage_en = power_ff;
    assign brake_release = brake_rel_ff;
    assign quick_stop_cmd = qs_cmd_ff;
    assign no_fault_out = state_ff[3] | state_ff[4] | state_ff[5];
    assign active_out = state_ff[5];
    assign error_flag = err_ind_ff | class4_ff;
    assign warn_flag = warn_ind_ff;
    assign safe_torque_off_trip = ~torque_ok;

    // ==========================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_init_seq;
        state_ff == ST_START && elec_init_done && !heavy_err |=> state_ff == ST_NOT_READY;
    endproperty
    a_init_seq: assert property (p_init_seq) else $error("start did not advance");

    property p_ready_gate;
        $rose(state_ff == ST_READY) |-> $past(ready_ok);
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("ready entered without conditions");

    property p_ready_drop;
        state_ff == ST_READY && !heavy_err && undervoltage |=> state_ff == ST_SW_ON_DIS;
    endproperty
    a_ready_drop: assert property (p_ready_drop) else $error("undervoltage kept ready");

    property p_auto_enable;
        state_ff == ST_SWITCHED_ON && !dis_req && !heavy_err && !torque_trip
            |=> state_ff == ST_OP_ENABLED && power_stage_en && active_out;
    endproperty
    a_auto_enable: assert property (p_auto_enable) else $error("switched on did not enable");

    property p_disable_cut;
        (state_ff == ST_OP_ENABLED || state_ff == ST_QUICK_STOP) && dis_req && !heavy_err && !torque_trip
            |=> state_ff == ST_SW_ON_DIS && !power_stage_en;
    endproperty
    a_disable_cut: assert property (p_disable_cut) else $error("disable did not cut power");

    property p_class1_qs;
        state_ff == ST_OP_ENABLED && class1_err && !dis_req && !torque_trip
            |=> state_ff == ST_QUICK_STOP && quick_stop_cmd;
    endproperty
    a_class1_qs: assert property (p_class1_qs) else $error("class 1 error not quick stopped");

    property p_heavy_fault;
        heavy_err && err_class != `ERR_CLASS_2
            |=> state_ff == ST_FAULT_REACT && !power_stage_en ##1 state_ff == ST_FAULT;
    endproperty
    a_heavy_fault: assert property (p_heavy_fault) else $error("class 3/4 response wrong");

    property p_class4_hold;
        class4_ff && state_ff == ST_FAULT && !heavy_err |=> state_ff == ST_FAULT;
    endproperty
    a_class4_hold: assert property (p_class4_hold) else $error("class 4 fault left");

    property p_priority;
        state_ff == ST_READY && en_req && dis_req |=> state_ff != ST_SWITCHED_ON;
    endproperty
    a_priority: assert property (p_priority) else $error("enable beat disable");

    property p_code;
        ##1 state_ff == ST_FAULT |-> op_state_code == `OPST_FAULT;
    endproperty
    a_code: assert property (p_code) else $error("state code mismatch");

endmodule

// ==== test/bus_controller_model.sv ====
// fieldbus controller model that issues command-bit pulses
`timescale 1ns/1ps

module bus_controller_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // bench request: bit 0 disable, 1 enable, 2 quick stop, 3 fault reset
    input wire logic go,
    input wire logic hold,
    input wire logic [3:0] cmd,
    // command bits
    output logic bus_disable,
    output logic bus_enable,
    output logic bus_quick_stop,
    output logic bus_fault_reset
);
    logic [3:0] bits_ff;

    // ==========================================
    // command bits
    // bits drop after a pulse unless hold is set, so a repeated command is a fresh rising edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_ff <= 4'h0;
        end else if (go) begin
            bits_ff <= cmd;
        end else if (!hold) begin
            bits_ff <= 4'h0;
        end
    end

    assign bus_disable = bits_ff[0];
    assign bus_enable = bits_ff[1];
    assign bus_quick_stop = bits_ff[2];
    assign bus_fault_reset = bits_ff[3];
endmodule

// ==== test/tb_drive_operating_state_machine.sv ====
// self-checking testbench of the drive operating-state machine
`timescale 1ns/1ps
`include "drive_state_regs.svh"

module tb_drive_operating_state_machine;
    import drive_state_pkg::*;

    logic clk, rst_n, elec_init_done, param_init_done, undervoltage, encoder_test_ok;
    logic speed_over_limit, torque_off_input_a, torque_off_input_b, motor_standstill;
    logic brake_fitted, brake_applied, fault_cause_active, err_valid;
    err_class_t err_class;
    logic bus_disable, bus_enable, bus_quick_stop, bus_fault_reset;
    logic local_enable_pin, local_fault_reset_pin, local_enable_assigned, local_fault_reset_assigned;
    logic power_stage_en, brake_release, quick_stop_cmd, no_fault_out, active_out;
    logic error_flag, warn_flag, safe_torque_off_trip, go, hold;
    logic [3:0] op_state_code, cmd;
    int n_mismatch, n_tests;

    drive_state_machine dut (.clk, .rst_n, .elec_init_done, .param_init_done, .undervoltage,
        .encoder_test_ok, .speed_over_limit, .torque_off_input_a, .torque_off_input_b,
        .motor_standstill, .brake_fitted, .brake_applied, .fault_cause_active, .err_valid,
        .err_class, .bus_disable, .bus_enable, .bus_quick_stop, .bus_fault_reset,
        .local_enable_pin, .local_fault_reset_pin, .local_enable_assigned,
        .local_fault_reset_assigned, .power_stage_en, .brake_release, .quick_stop_cmd,
        .op_state_code, .no_fault_out, .active_out, .error_flag, .warn_flag, .safe_torque_off_trip);

    bus_controller_model ctrl (.clk, .rst_n, .go, .hold, .cmd, .bus_disable, .bus_enable,
        .bus_quick_stop, .bus_fault_reset);

    // ==========================================
    // helpers
    task automatic give_verdict();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a hang here ends the run rather than stalling it
    task automatic wait_code(input logic [3:0] exp);
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (op_state_code === exp) break;
        end
        chk(op_state_code, exp);
        if (op_state_code !== exp) give_verdict();
    endtask

    task automatic settle(input int n, input logic [3:0] exp);
        repeat (n) @(posedge clk);
        #1;
        chk(op_state_code, exp);
    endtask

    task automatic bus_cmd(input logic [3:0] mask);
        @(posedge clk);
        go <= 1'b1;
        cmd <= mask;
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic err(input err_class_t c);
        @(posedge clk);
        err_valid <= 1'b1;
        err_class <= c;
        @(posedge clk);
        err_valid <= 1'b0;
        #1;
    endtask

    task automatic go_op();
        bus_cmd(4'h2);
        wait_code(`OPST_OP_ENABLED);
    endtask

    // ==========================================
    // scenarios
    task automatic t_startup();
        @(posedge clk);
        #1;
        chk(op_state_code, `OPST_START);
        chk(4'(safe_torque_off_trip), 4'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        elec_init_done <= 1'b1;
        wait_code(`OPST_NOT_READY);
        @(posedge clk);
        param_init_done <= 1'b1;
        wait_code(`OPST_SW_ON_DIS);
        @(posedge clk);
        undervoltage <= 1'b0;
        settle(6, `OPST_SW_ON_DIS);
        @(posedge clk);
        encoder_test_ok <= 1'b1;
        wait_code(`OPST_READY);
    endtask

    task automatic t_fallback();
        @(posedge clk);
        torque_off_input_a <= 1'b0;
        wait_code(`OPST_SW_ON_DIS);
        chk(4'(safe_torque_off_trip), 4'h1);
        @(posedge clk);
        torque_off_input_a <= 1'b1;
        wait_code(`OPST_READY);
        @(posedge clk);
        speed_over_limit <= 1'b1;
        wait_code(`OPST_SW_ON_DIS);
        @(posedge clk);
        speed_over_limit <= 1'b0;
        wait_code(`OPST_READY);
    endtask

    task automatic t_enable();
        @(posedge clk);
        undervoltage <= 1'b1;
        wait_code(`OPST_SW_ON_DIS);
        hold <= 1'b1;
        bus_cmd(4'h2);
        @(posedge clk);
        undervoltage <= 1'b0;
        wait_code(`OPST_READY);
        settle(5, `OPST_READY);
        @(posedge clk);
        hold <= 1'b0;
        bus_cmd(4'h3);
        settle(5, `OPST_READY);
        bus_cmd(4'h2);
        wait_code(`OPST_SWITCHED_ON);
        settle(1, `OPST_OP_ENABLED);
        chk({2'h0, power_stage_en, brake_release}, 4'h3);
        chk({2'h0, no_fault_out, active_out}, 4'h3);
        bus_cmd(4'h1);
        wait_code(`OPST_SW_ON_DIS);
        chk({2'h0, power_stage_en, no_fault_out}, 4'h0);
    endtask

    task automatic t_class1();
        go_op();
        err(3'h1);
        chk(op_state_code, `OPST_QUICK_STOP);
        chk(4'(quick_stop_cmd), 4'h1);
        bus_cmd(4'h8);
        wait_code(`OPST_OP_ENABLED);
        chk(4'(quick_stop_cmd), 4'h0);
        err(3'h1);
        bus_cmd(4'h1);
        wait_code(`OPST_SW_ON_DIS);
        chk(4'(power_stage_en), 4'h0);
    endtask

    task automatic t_class0();
        go_op();
        err(3'h0);
        chk(op_state_code, `OPST_OP_ENABLED);
        chk({error_flag, warn_flag}, 4'h3);
        bus_cmd(4'h8);
        settle(3, `OPST_OP_ENABLED);
        chk({error_flag, warn_flag}, 4'h0);
    endtask

    task automatic t_class2();
        err(3'h2);
        chk(op_state_code, `OPST_FAULT_REACT);
        chk({quick_stop_cmd, power_stage_en}, 4'h3);
        settle(4, `OPST_FAULT_REACT);
        @(posedge clk);
        motor_standstill <= 1'b1;
        settle(2, `OPST_FAULT_REACT);
        chk({1'h0, quick_stop_cmd, brake_release, power_stage_en}, 4'h1);
        @(posedge clk);
        brake_applied <= 1'b1;
        fault_cause_active <= 1'b1;
        wait_code(`OPST_FAULT);
        chk(4'(power_stage_en), 4'h0);
        bus_cmd(4'h8);
        settle(3, `OPST_FAULT);
        @(posedge clk);
        fault_cause_active <= 1'b0;
        motor_standstill <= 1'b0;
        brake_applied <= 1'b0;
        bus_cmd(4'h8);
        wait_code(`OPST_SW_ON_DIS);
        chk(4'(error_flag), 4'h0);
    endtask

    task automatic t_local();
        @(posedge clk);
        local_enable_assigned <= 1'b1;
        local_enable_pin <= 1'b1;
        wait_code(`OPST_OP_ENABLED);
        @(posedge clk);
        local_enable_pin <= 1'b0;
        wait_code(`OPST_SW_ON_DIS);
        chk(4'(power_stage_en), 4'h0);
    endtask

    task automatic t_class3();
        go_op();
        err(3'h3);
        chk(op_state_code, `OPST_FAULT_REACT);
        chk(4'(power_stage_en), 4'h0);
        wait_code(`OPST_FAULT);
        bus_cmd(4'hC);
        settle(3, `OPST_FAULT);
        @(posedge clk);
        local_fault_reset_assigned <= 1'b1;
        local_fault_reset_pin <= 1'b1;
        wait_code(`OPST_SW_ON_DIS);
        @(posedge clk);
        local_fault_reset_pin <= 1'b0;
    endtask

    // quick stop by command, then a torque-off loss while the power stage is still on
    task automatic t_sto();
        @(posedge clk);
        brake_fitted <= 1'b0;
        go_op();
        chk(4'(brake_release), 4'h0);
        bus_cmd(4'h4);
        wait_code(`OPST_QUICK_STOP);
        bus_cmd(4'h8);
        settle(3, `OPST_QUICK_STOP);
        chk(4'(quick_stop_cmd), 4'h1);
        @(posedge clk);
        torque_off_input_b <= 1'b0;
        wait_code(`OPST_FAULT_REACT);
        chk({2'h0, power_stage_en, safe_torque_off_trip}, 4'h1);
        wait_code(`OPST_FAULT);
        @(posedge clk);
        torque_off_input_b <= 1'b1;
        bus_cmd(4'h8);
        wait_code(`OPST_SW_ON_DIS);
    endtask

    task automatic t_class4();
        err(3'h4);
        wait_code(`OPST_FAULT);
        bus_cmd(4'h8);
        settle(4, `OPST_FAULT);
        chk(4'(error_flag), 4'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        settle(3, `OPST_START);
        chk(4'(error_flag), 4'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_code(`OPST_READY);
    endtask

    // ==========================================
    // clock and main sequence
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        {rst_n, elec_init_done, param_init_done, encoder_test_ok, speed_over_limit} = 5'h00;
        {motor_standstill, brake_applied, fault_cause_active, err_valid, go, hold} = 6'h00;
        {local_enable_pin, local_fault_reset_pin, local_enable_assigned} = 3'h0;
        local_fault_reset_assigned = 1'b0;
        {undervoltage, torque_off_input_a, torque_off_input_b, brake_fitted} = 4'hF;
        err_class = 3'h0;
        cmd = 4'h0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (2) @(posedge clk);
        t_startup();
        t_fallback();
        t_enable();
        t_class1();
        t_class0();
        t_class2();
        t_local();
        t_class3();
        t_sto();
        t_class4();
        give_verdict();
    end
endmodule
